// [src/pport_defines.vh]
`ifndef PPORT_DEFINES_VH
`define PPORT_DEFINES_VH
// register indices on reg_addr
`define PPORT_REG_DATA 3'h0
`define PPORT_REG_STAT 3'h1
`define PPORT_REG_CTRL 3'h2
`define PPORT_REG_MODE 3'h3
`define PPORT_REG_PDIN 3'h4
`define PPORT_REG_CMD 3'h5
// control register fields
`define PPORT_CTRL_INIT 0
`define PPORT_CTRL_CHOOSE 1
`define PPORT_CTRL_END_ECP 2
`define PPORT_CTRL_IRQ_EN 3
`define PPORT_CTRL_DMA_EN 4
`define PPORT_CTRL_RST 8'h0_0
// mode register encodings
`define PPORT_MODE_COMPAT 2'h0
`define PPORT_MODE_ECP 2'h1
`define PPORT_MODE_EPP 2'h2
`define PPORT_MODE_FIFO 2'h3
// timing
`define PPORT_CLK_NS 40
`define PPORT_INIT_PULSE_NS 1000
// init pulse width rounded up to whole clocks, sized for the counter
`define PPORT_INIT_PULSE_CYC 8'h19
`define PPORT_STROBE_NS 500
// strobe width rounded up to whole clocks, sized for the counter
`define PPORT_STROBE_CYC 8'h0d
`define PPORT_ACC_WAIT_CYC 3'h2
`endif

// [src/pport_host_port.v]
// Operation
// - compat: pulse reverse-request low resets peripheral
// - ecp: reverse-request low turns channel around
// - ecp reverse with choose high: release data
// - epp: reverse-request low starts termination cycle
// - ecp: ack status gates driving data again
// - data lines carry address, data or commands
// - dma request only in ecp or fifo
// - irq three-state; epp source rising edge
// - read strobe drives selected register onto bus
// - write strobe loads selected register from bus
// - ready held inactive until access completes
// - reset initialises all internal registers except the fifo storage
// - controls open-drain in compat, else push-pull
// - ecp: choose high; low ends ecp
// - ecp: peripheral trouble raises error interrupt
`timescale 1ns/100ps
`default_nettype none
`include "pport_defines.vh"

// ----------------------------------------
// data path fifo
// ----------------------------------------
module pport_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    assign in_ready = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // storage write
    always @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // pointers and fill count
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push & ~pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop & ~push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule // pport_fifo

// ----------------------------------------
// parallel port host side
// ----------------------------------------
module pport_host_port #(
    parameter FIFO_DEPTH = 16
) (
    input wire sys_clk,
    input wire rst_b,
    input wire port_regs_cs_n,
    input wire bus_read_n,
    input wire bus_write_n,
    input wire [2:0] reg_addr,
    input wire [7:0] host_data_in,
    output reg [7:0] host_data_out,
    output reg host_data_oe,
    output reg bus_cycle_ready_out,
    output reg bus_cycle_ready_oe,
    input wire [7:0] port_data_in,
    output reg [7:0] port_data_out,
    output reg port_data_oe,
    output reg reverse_req_n_out,
    output reg reverse_req_n_oe,
    output reg host_choose_out,
    output reg host_choose_oe,
    output reg data_strobe_n_out,
    output reg data_strobe_n_oe,
    output reg host_cmd_n_out,
    output reg host_cmd_n_oe,
    input wire peripheral_ack_status_in,
    input wire peripheral_trouble_n,
    input wire peripheral_busy,
    input wire peripheral_online,
    input wire peripheral_strobe_ack_n,
    output reg port_dma_request,
    input wire port_dma_ack_n,
    output reg port_irq,
    output reg port_irq_oe
);
    // drain states
    localparam ST_IDLE = 4'b0001;
    localparam ST_SETUP = 4'b0010;
    localparam ST_STROBE = 4'b0100;
    localparam ST_HOLD = 4'b1000;

    reg [7:0] ctrl_q;
    reg [1:0] mode_q;
    reg [7:0] latch_q;
    reg [7:0] pd_byte_q;
    reg pd_cmd_q;
    reg [3:0] st_q;
    reg [7:0] tcnt_q;
    reg [7:0] init_cnt_q;
    reg epp_term_q;
    reg [2:0] wait_q;
    reg wr_done_q;
    reg rd_done_q;
    reg ack_prev_q;
    reg irq_flag_q;
    reg err_flag_q;
    reg turned_q;
    reg [7:0] rd_mux;
    reg ctrl_init_n;
    reg choose_lvl;

    wire sel = ~port_regs_cs_n;
    wire dma_cyc = ~port_dma_ack_n;
    wire rd_act = ~bus_read_n & (sel | dma_cyc);
    wire wr_act = ~bus_write_n & (sel | dma_cyc);
    wire is_ecp = (mode_q == `PPORT_MODE_ECP);
    wire is_epp = (mode_q == `PPORT_MODE_EPP);
    wire is_fifo = (mode_q == `PPORT_MODE_FIFO);
    wire is_compat = (mode_q == `PPORT_MODE_COMPAT);
    wire fifo_mode = is_ecp | is_fifo;
    wire reverse = is_ecp & ~ctrl_init_n;
    wire wr_fifo = wr_act & ~wr_done_q & fifo_mode & ~reverse
        & (dma_cyc | reg_addr == `PPORT_REG_DATA | reg_addr == `PPORT_REG_CMD);
    wire wr_reg = wr_act & ~wr_done_q & sel & ~wr_fifo;
    wire f_in_ready;
    wire f_out_valid;
    wire [8:0] f_out_data;
    wire f_pop = (st_q == ST_IDLE) & fifo_mode & ~turned_q & ~peripheral_busy;
    wire f_stall = wr_act & ~wr_done_q & ~f_in_ready & fifo_mode & ~reverse;
    wire ack_rise = peripheral_strobe_ack_n & ~ack_prev_q;
    wire trouble = is_ecp & ~peripheral_trouble_n;

    // ----------------------------------------
    // forward data buffer
    // ----------------------------------------
    pport_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_data({reg_addr == `PPORT_REG_CMD & ~dma_cyc, host_data_in}),
        .in_valid(wr_fifo),
        .in_ready(f_in_ready),
        .out_data(f_out_data),
        .out_valid(f_out_valid),
        .out_ready(f_pop)
    );

    // ----------------------------------------
    // register read selection
    // ----------------------------------------
    always @* begin
        case (reg_addr)
            `PPORT_REG_DATA: rd_mux = reverse ? latch_q : pd_byte_q;
            `PPORT_REG_STAT: rd_mux = {~f_in_ready, ~f_out_valid, err_flag_q, irq_flag_q,
                peripheral_busy, peripheral_online, peripheral_strobe_ack_n,
                peripheral_ack_status_in};
            `PPORT_REG_CTRL: rd_mux = ctrl_q;
            `PPORT_REG_MODE: rd_mux = {6'h0_0, mode_q};
            `PPORT_REG_PDIN: rd_mux = port_data_in;
            default: rd_mux = 8'h0_0;
        endcase
    end

    // levels of the reverse request and choose lines
    always @* begin
        ctrl_init_n = 1'b1;
        choose_lvl = ctrl_q[`PPORT_CTRL_CHOOSE];
        if (init_cnt_q != 8'h0_0) begin
            ctrl_init_n = 1'b0;
        end else if (is_ecp & ctrl_q[`PPORT_CTRL_INIT]) begin
            ctrl_init_n = 1'b0;
        end
        if (is_ecp) begin
            choose_lvl = ~ctrl_q[`PPORT_CTRL_END_ECP];
        end
    end

    // ----------------------------------------
    // host bus slave
    // ----------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            host_data_out <= 8'h0_0;
            host_data_oe <= 1'b0;
            bus_cycle_ready_out <= 1'b0;
            bus_cycle_ready_oe <= 1'b0;
            wait_q <= 3'h0;
            wr_done_q <= 1'b0;
            rd_done_q <= 1'b0;
            ctrl_q <= `PPORT_CTRL_RST;
            mode_q <= `PPORT_MODE_COMPAT;
            pd_byte_q <= 8'h0_0;
            init_cnt_q <= 8'h0_0;
            epp_term_q <= 1'b0;
        end else begin
            host_data_out <= rd_mux;
            host_data_oe <= rd_act;
            rd_done_q <= rd_act;
            if (~wr_act) begin
                wr_done_q <= 1'b0;
            end else if (wr_fifo & f_in_ready | wr_reg) begin
                wr_done_q <= 1'b1;
            end
            // wait states at each new access, longer while fifo is full
            if ((rd_act & ~rd_done_q) | (wr_act & ~wr_done_q & wait_q == 3'h0)) begin
                wait_q <= `PPORT_ACC_WAIT_CYC;
            end else if (wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
            end
            bus_cycle_ready_oe <= (wait_q > 3'h1) | f_stall
                | (rd_act & ~rd_done_q);
            if (wr_reg) begin
                case (reg_addr)
                    `PPORT_REG_DATA: pd_byte_q <= host_data_in;
                    `PPORT_REG_CTRL: begin
                        ctrl_q <= host_data_in;
                        if (host_data_in[`PPORT_CTRL_INIT] & (is_compat | is_epp)) begin
                            init_cnt_q <= `PPORT_INIT_PULSE_CYC;
                            epp_term_q <= is_epp;
                        end
                    end
                    `PPORT_REG_MODE: mode_q <= host_data_in[1:0];
                    default: ;
                endcase
            end else begin
                if (init_cnt_q != 8'h0_0) begin
                    init_cnt_q <= init_cnt_q - 8'h0_1;
                end
                if (init_cnt_q == 8'h0_1) begin
                    ctrl_q[`PPORT_CTRL_INIT] <= 1'b0;
                    if (epp_term_q) begin
                        mode_q <= `PPORT_MODE_COMPAT;
                    end
                    epp_term_q <= 1'b0;
                end
                if (is_ecp & ctrl_q[`PPORT_CTRL_END_ECP]) begin
                    mode_q <= `PPORT_MODE_COMPAT;
                    ctrl_q[`PPORT_CTRL_END_ECP] <= 1'b0;
                    ctrl_q[`PPORT_CTRL_INIT] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // port side drain and turnaround
    // ----------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
            tcnt_q <= 8'h0_0;
            pd_cmd_q <= 1'b0;
            port_data_out <= 8'h0_0;
            port_data_oe <= 1'b0;
            latch_q <= 8'h0_0;
            turned_q <= 1'b0;
        end else begin
            // released while reversed, kept off until ack returns high
            if (reverse & choose_lvl) begin
                turned_q <= 1'b1;
            end else if (peripheral_ack_status_in) begin
                turned_q <= 1'b0;
            end
            if (reverse & ~peripheral_ack_status_in) begin
                latch_q <= port_data_in;
            end
            port_data_oe <= ~(reverse & choose_lvl) & ~turned_q
                & (ctrl_init_n | ~is_ecp);
            case (st_q)
                ST_IDLE: begin
                    if (~fifo_mode) begin
                        port_data_out <= pd_byte_q;
                        pd_cmd_q <= 1'b0;
                    end else if (f_out_valid & f_pop) begin
                        port_data_out <= f_out_data[7:0];
                        pd_cmd_q <= f_out_data[8];
                        tcnt_q <= `PPORT_STROBE_CYC;
                        st_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    st_q <= ST_STROBE;
                end
                ST_STROBE: begin
                    tcnt_q <= tcnt_q - 8'h0_1;
                    if (tcnt_q == 8'h0_1) begin
                        st_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (~peripheral_busy) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // control outputs, dma and interrupt
    // ----------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reverse_req_n_out <= 1'b1;
            reverse_req_n_oe <= 1'b0;
            host_choose_out <= 1'b0;
            host_choose_oe <= 1'b1;
            data_strobe_n_out <= 1'b1;
            data_strobe_n_oe <= 1'b0;
            host_cmd_n_out <= 1'b1;
            host_cmd_n_oe <= 1'b0;
            port_dma_request <= 1'b0;
            port_irq <= 1'b0;
            port_irq_oe <= 1'b0;
            ack_prev_q <= 1'b1;
            irq_flag_q <= 1'b0;
            err_flag_q <= 1'b0;
        end else begin
            reverse_req_n_out <= ctrl_init_n;
            host_choose_out <= choose_lvl;
            data_strobe_n_out <= ~(st_q == ST_STROBE);
            host_cmd_n_out <= ~(pd_cmd_q & is_ecp);
            // open-drain drives only the low level
            reverse_req_n_oe <= ~is_compat | ~ctrl_init_n;
            host_choose_oe <= ~is_compat | ~choose_lvl;
            data_strobe_n_oe <= ~is_compat | (st_q == ST_STROBE);
            host_cmd_n_oe <= ~is_compat;
            port_dma_request <= fifo_mode & ctrl_q[`PPORT_CTRL_DMA_EN]
                & f_in_ready & ~reverse & ~wr_act;
            ack_prev_q <= peripheral_strobe_ack_n;
            // event wins over a status read in the same cycle
            if (is_epp & ack_rise) begin
                irq_flag_q <= 1'b1;
            end else if (rd_act & ~rd_done_q & sel & reg_addr == `PPORT_REG_STAT) begin
                irq_flag_q <= 1'b0;
            end
            if (trouble) begin
                err_flag_q <= 1'b1;
            end else if (rd_act & ~rd_done_q & sel & reg_addr == `PPORT_REG_STAT) begin
                err_flag_q <= 1'b0;
            end
            port_irq <= irq_flag_q | err_flag_q;
            port_irq_oe <= ctrl_q[`PPORT_CTRL_IRQ_EN];
        end
    end
endmodule // pport_host_port
`default_nettype wire

// [bench/pport_host_port_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module pport_host_port_properties (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic port_regs_cs_n,
    input wire logic bus_read_n,
    input wire logic bus_write_n,
    input wire logic port_dma_ack_n,
    input wire logic host_data_oe,
    input wire logic bus_cycle_ready_out,
    input wire logic bus_cycle_ready_oe,
    input wire logic port_data_oe,
    input wire logic [7:0] port_data_out,
    input wire logic data_strobe_n_out,
    input wire logic reverse_req_n_out,
    input wire logic host_choose_out,
    input wire logic host_choose_oe,
    input wire logic peripheral_ack_status_in,
    input wire logic port_dma_request,
    input wire logic port_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // start of a selected register access
    sequence s_acc_start;
        !port_regs_cs_n && ($fell(bus_write_n) || $fell(bus_read_n));
    endsequence
    // data held for the first strobe cycles
    sequence s_data_held;
        (port_data_oe && $stable(port_data_out))[*8];
    endsequence
    chk_ready_stretch: assert property (s_acc_start |-> ##[1:2] bus_cycle_ready_oe)
        else $error("ready not pulled after access start");
    chk_ready_idle: assert property ((bus_read_n && bus_write_n)[*2] |-> !bus_cycle_ready_oe)
        else $error("ready held with no access");
    chk_ready_drain: assert property (bus_cycle_ready_oe |-> !bus_cycle_ready_out)
        else $error("ready driven high");
    chk_read_drive: assert property (!bus_read_n && !port_regs_cs_n |=> host_data_oe)
        else $error("read data not driven");
    chk_bus_release: assert property (bus_read_n || (port_regs_cs_n && port_dma_ack_n)
        |=> !host_data_oe)
        else $error("host bus driven outside read");
    chk_rev_release: assert property (!reverse_req_n_out && host_choose_out
        && !peripheral_ack_status_in |=> !port_data_oe)
        else $error("data lines driven while reversed");
    chk_strobe_data: assert property ($fell(data_strobe_n_out) |-> s_data_held)
        else $error("data moved during strobe");
    chk_reset_clear: assert property (disable iff (1'b0) !rst_b |-> host_choose_oe
        && reverse_req_n_out && !port_dma_request && !port_irq && !host_data_oe)
        else $error("outputs not cleared in reset");
endmodule // pport_host_port_properties

bind pport_host_port pport_host_port_properties u_chk (
    .sys_clk, .rst_b, .port_regs_cs_n, .bus_read_n, .bus_write_n, .port_dma_ack_n,
    .host_data_oe, .bus_cycle_ready_out, .bus_cycle_ready_oe, .port_data_oe,
    .port_data_out, .data_strobe_n_out, .reverse_req_n_out, .host_choose_out,
    .host_choose_oe, .peripheral_ack_status_in, .port_dma_request, .port_irq
);
`default_nettype wire

// [bench/pport_periph_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// peripheral on the cable
// ----------------------------------------
module pport_periph_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic stall,
    input wire logic [7:0] rev_byte,
    input wire logic reverse_req_n_out,
    input wire logic host_choose_out,
    input wire logic data_strobe_n_out,
    input wire logic [7:0] port_data_out,
    input wire logic port_data_oe,
    output logic [7:0] port_data_in,
    output logic peripheral_ack_status_in,
    output logic peripheral_busy,
    output logic got_q,
    output logic [7:0] got_byte_q
);
    logic strb_q;
    logic [7:0] last_q;
    // handshake, busy and capture of strobed bytes
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {peripheral_ack_status_in, peripheral_busy, strb_q, got_q} <= 4'ha;
            {got_byte_q, last_q} <= 16'h0000;
        end else begin
            peripheral_ack_status_in <= reverse_req_n_out | ~host_choose_out;
            peripheral_busy <= stall | ~data_strobe_n_out;
            strb_q <= data_strobe_n_out;
            got_q <= strb_q & ~data_strobe_n_out;
            if (strb_q & ~data_strobe_n_out)
                got_byte_q <= port_data_out;
            if (port_data_oe)
                last_q <= port_data_out;
        end
    end
    // wire level: host, peripheral after ack, else a changed value
    assign port_data_in = port_data_oe ? port_data_out
        : (peripheral_ack_status_in ? ~last_q : rev_byte);
endmodule // pport_periph_model
`default_nettype wire

// [bench/tb_pport_host_port.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pport_defines.vh"
module tb_pport_host_port;
    logic sys_clk = 0;
    logic rst_b = 1;
    logic cs_n = 1, rd_n = 1, wr_n = 1, dack_n = 1, trb_n = 1, sack_n = 1, stall = 0, rnd_on = 0;
    logic [2:0] addr = 0;
    logic [7:0] wdat = 0, rev = 0, rd, v;
    logic [31:0] seed = 32'hb936_c15e;
    logic [7:0] q[$];
    logic [7:0] seen[$];
    int miscompares = 0, cmp_count = 0, n;
    wire [7:0] hdo, pdo, pdi, gotb;
    wire rdy_oe, poe, rq, rq_oe, ch, st, ack, busy, drq, irq, irq_oe, got;
    // ----------------------------------------
    // design and peripheral
    // ----------------------------------------
    pport_host_port #(.FIFO_DEPTH(16)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .port_regs_cs_n(cs_n), .bus_read_n(rd_n), .bus_write_n(wr_n), .reg_addr(addr),
        .host_data_in(wdat), .host_data_out(hdo), .host_data_oe(), .bus_cycle_ready_out(),
        .bus_cycle_ready_oe(rdy_oe), .port_data_in(pdi), .port_data_out(pdo),
        .port_data_oe(poe), .reverse_req_n_out(rq), .reverse_req_n_oe(rq_oe),
        .host_choose_out(ch), .host_choose_oe(), .data_strobe_n_out(st), .data_strobe_n_oe(),
        .host_cmd_n_out(), .host_cmd_n_oe(), .peripheral_ack_status_in(ack),
        .peripheral_trouble_n(trb_n), .peripheral_busy(busy), .peripheral_online(1'b1),
        .peripheral_strobe_ack_n(sack_n), .port_dma_request(drq), .port_dma_ack_n(dack_n),
        .port_irq(irq), .port_irq_oe(irq_oe));
    pport_periph_model u_per (.sys_clk(sys_clk), .rst_b(rst_b), .stall(stall), .rev_byte(rev),
        .reverse_req_n_out(rq), .host_choose_out(ch), .data_strobe_n_out(st),
        .port_data_out(pdo), .port_data_oe(poe), .port_data_in(pdi),
        .peripheral_ack_status_in(ack), .peripheral_busy(busy), .got_q(got), .got_byte_q(gotb));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    always #20 sys_clk = ~sys_clk;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    // one bus access held until ready is released
    task automatic acc(input logic w, input logic d, input logic [2:0] a, input logic [7:0] x);
        int k;
        @(posedge sys_clk);
        #1;
        {cs_n, dack_n, addr, wdat, rd_n, wr_n} = {d, !d, a, x, w, !w};
        k = 0;
        do @(posedge sys_clk); while (rdy_oe !== 1'b1 && ++k < 2000);
        do @(posedge sys_clk); while (rdy_oe !== 1'b0 && ++k < 4000);
        if (k >= 2000)
            miscompares++;
        rd = hdo;
        #1;
        {rd_n, wr_n, cs_n, dack_n} = 4'hf;
    endtask
    // count the cycles of one low pulse on reverse request
    task automatic pulse;
        n = 0;
        do @(posedge sys_clk); while (rq !== 1'b0 && ++n < 10);
        chk("init_oe", 8'h01, {7'h00, rq_oe});
        n = 1;
        do @(posedge sys_clk); while (rq === 1'b0 && ++n < 99);
    endtask
    task automatic wrap_up;
        $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // random stall and capture during the drain
    always @(posedge sys_clk) begin
        if (got === 1'b1)
            seen.push_back(gotb);
        #1;
        if (rnd_on) begin
            seed = nxt(seed);
            {stall, sack_n} = {seed[0] & seed[1], seed[2]};
        end
    end
    initial begin
        #(40 * 20000);
        miscompares++;
        wrap_up();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #5 rst_b = 0;
        repeat (20) @(posedge sys_clk);
        #1 rst_b = 1;
        acc(0, 0, `PPORT_REG_CTRL, 0);
        chk("ctrl_rst", `PPORT_CTRL_RST, rd);
        acc(0, 0, 3'h7, 0);
        chk("reserved", 8'h00, rd);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            acc(1, 0, `PPORT_REG_MODE, i[7:0]);
            acc(0, 0, `PPORT_REG_MODE, 0);
            chk("mode", i[7:0], rd);
        end
        seed = nxt(seed);
        acc(1, 0, 3'h6, seed[15:8]);
        acc(0, 0, 3'h6, 0);
        chk("unmapped", 8'h00, rd);
        acc(1, 0, `PPORT_REG_MODE, 0);
        acc(1, 0, `PPORT_REG_DATA, seed[7:0]);
        chk("compat_data", seed[7:0], pdo);
        acc(0, 0, `PPORT_REG_PDIN, 0);
        chk("pdin", seed[7:0], rd);
        $display("test registers done");
        fork
            acc(1, 0, `PPORT_REG_CTRL, 8'h01);
            pulse();
        join
        chk("init_len", `PPORT_INIT_PULSE_CYC, n[7:0]);
        chk("init_oe_off", 8'h00, {7'h00, rq_oe});
        acc(1, 0, `PPORT_REG_CTRL, 0);
        acc(1, 0, `PPORT_REG_MODE, `PPORT_MODE_EPP);
        sack_n = 0;
        repeat (2) @(posedge sys_clk);
        #1 sack_n = 1;
        repeat (3) @(posedge sys_clk);
        chk("epp_irq", 8'h01, {7'h00, irq});
        acc(0, 0, `PPORT_REG_STAT, 0);
        repeat (2) @(posedge sys_clk);
        chk("irq_clear", 8'h00, {7'h00, irq});
        fork
            acc(1, 0, `PPORT_REG_CTRL, 8'h01);
            pulse();
        join
        acc(0, 0, `PPORT_REG_MODE, 0);
        chk("epp_end", `PPORT_MODE_COMPAT, rd);
        acc(1, 0, `PPORT_REG_CTRL, 0);
        $display("test init pulse done");
        rev = seed[23:16];
        acc(1, 0, `PPORT_REG_MODE, `PPORT_MODE_ECP);
        acc(1, 0, `PPORT_REG_CTRL, 8'h02);
        chk("choose", 8'h01, {7'h00, ch});
        acc(1, 0, `PPORT_REG_CTRL, 8'h03);
        repeat (4) @(posedge sys_clk);
        chk("rev_req", 8'h00, {7'h00, rq});
        chk("rev_oe", 8'h00, {7'h00, poe});
        acc(0, 0, `PPORT_REG_DATA, 0);
        chk("rev_data", rev, rd);
        acc(1, 0, `PPORT_REG_CTRL, 8'h0a);
        trb_n = 0;
        repeat (3) @(posedge sys_clk);
        chk("err_irq", 8'h01, {7'h00, irq});
        chk("irq_oe", 8'h01, {7'h00, irq_oe});
        acc(0, 0, `PPORT_REG_STAT, 0);
        chk("err_set", 8'h01, {7'h00, rd[5]});
        trb_n = 1;
        acc(0, 0, `PPORT_REG_STAT, 0);
        chk("err_clear", 8'h00, {7'h00, rd[5]});
        acc(1, 0, `PPORT_REG_CTRL, 8'h04);
        acc(0, 0, `PPORT_REG_MODE, 0);
        chk("ecp_end", `PPORT_MODE_COMPAT, rd);
        $display("test ecp done");
        acc(1, 0, `PPORT_REG_CTRL, 8'h10);
        chk("dma_compat", 8'h00, {7'h00, drq});
        stall = 1;
        acc(1, 0, `PPORT_REG_MODE, `PPORT_MODE_FIFO);
        repeat (2) @(posedge sys_clk);
        chk("dma_fifo", 8'h01, {7'h00, drq});
        for (int i = 0; i < 16; i++) begin
            seed = nxt(seed);
            q.push_back(seed[7:0]);
            acc(1, i[0], `PPORT_REG_DATA, seed[7:0]);
        end
        acc(0, 0, `PPORT_REG_STAT, 0);
        chk("full", 8'h01, {7'h00, rd[7]});
        v = ~q[0];
        q.push_back(v);
        fork
            acc(1, 0, `PPORT_REG_DATA, v);
            begin
                repeat (30) @(posedge sys_clk);
                chk("stretch", 8'h01, {7'h00, rdy_oe});
                rnd_on = 1;
            end
        join
        n = 0;
        do @(posedge sys_clk); while (seen.size() < 17 && ++n < 4000);
        if (n >= 4000)
            miscompares++;
        rnd_on = 0;
        stall = 0;
        for (int i = 0; i < 17; i++)
            chk("drain", q[i], seen[i]);
        acc(0, 0, `PPORT_REG_STAT, 0);
        chk("empty", 8'h01, {7'h00, rd[6]});
        $display("test fifo done");
        wrap_up();
    end
endmodule // tb_pport_host_port
`default_nettype wire
